// ===== pkg/sss_pkg.sv
// sss_pkg: constants for the status summary and queue block
// assumes: one clock domain, synchronous active-high reset
package sss_pkg;
    // ************************************************
    // status byte bit positions
    // ************************************************
    localparam int STB_ERRQ_BIT = 2;
    localparam int STB_FAULT_BIT = 3;
    localparam int STB_REPLY_BIT = 4;
    localparam int STB_RQ_BIT = 6;
    localparam int STB_NORM_BIT = 7;
    // ************************************************
    // group roll-up positions
    // ************************************************
    localparam int TOP_PHASE_BIT = 13;
    localparam int OP_PHASE_BASE = 0;
    localparam int QU_PHASE_BASE = 1;
    localparam int NUM_PHASES = 3;
    // ************************************************
    // per-phase field positions and used-bit masks
    // ************************************************
    localparam int OPB_MEASURE_RUNNING = 4;
    localparam int OPB_MEASURE_ARMED = 5;
    localparam int OPB_SEQ_RUNNING = 6;
    localparam int OPB_SEQ_ARMED = 7;
    localparam int OPB_CONSTANT_VOLTAGE_MODE = 8;
    localparam int OPB_SOFT_RAMP_ACTIVE = 9;
    localparam int OPB_SYNC_RUNNING = 10;
    localparam logic [15:0] OP_USED_MASK = 16'h07F0;
    localparam int QB_HIGH_VOLTAGE_TRIP = 0;
    localparam int QB_RMS_CURRENT_LIMITING = 12;
    localparam logic [15:0] QU_USED_MASK = 16'h1FFF;
    localparam logic [15:0] OP_ROLLUP_MASK = 16'h0007;
    localparam logic [15:0] QU_ROLLUP_MASK = 16'h000E;
    // ************************************************
    // reset values and error codes
    // ************************************************
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] ERR_QUEUE_OVERFLOW = 16'hFEA2; // -350
    localparam int ERR_TEXT_W = 16;
    localparam logic [15:0] ERR_OVERFLOW_TEXT = 16'h0001;
    // ************************************************
    // register-select encoding for the read port
    // ************************************************
    typedef enum logic [3:0] {
        SSS_SEL_OP_ROLLUP,
        SSS_SEL_OP_STATE,
        SSS_SEL_QU_ROLLUP,
        SSS_SEL_QU_STATE,
        SSS_SEL_TOP_OP,
        SSS_SEL_TOP_QU
    } sss_sel_t;
endpackage : sss_pkg

// ===== pkg/sss_grp_if.sv
// sss_grp_if: signals of one status group
// assumes: driven by the top, served by sss_group
`timescale 1ns/1ps
`default_nettype none
interface sss_grp_if;
    logic [15:0] cond;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] enable;
    logic        clear;
    logic [15:0] event_q;
    logic        summary;
    modport grp (input cond, ptr, ntr, enable, clear,
                 output event_q, summary);
    modport user (output cond, ptr, ntr, enable, clear,
                  input event_q, summary);
endinterface : sss_grp_if
`default_nettype wire

// ===== logic/sss_group.sv
// sss_group: condition, transition filters, event latch, enable
// assumes: condition is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module sss_group
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    sss_grp_if.grp    g
);
    logic [15:0] cond_reg;
    logic [15:0] event_reg;
    logic [15:0] rise;
    logic [15:0] fall;
    assign rise = g.cond & ~cond_reg & g.ptr;
    assign fall = ~g.cond & cond_reg & g.ntr;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cond_reg <= sss_pkg::REG_RESET;
        else
            cond_reg <= g.cond;
    end
    // set wins over clear so no edge is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            event_reg <= sss_pkg::REG_RESET;
        else if (g.clear)
            event_reg <= rise | fall;
        else
            event_reg <= event_reg | rise | fall;
    end
    assign g.event_q = event_reg;
    assign g.summary = |(event_reg & g.enable);
endmodule : sss_group
`default_nettype wire

// ===== logic/sss_queue.sv
// sss_queue: plain fifo, optional overflow substitution
// assumes: push and pop synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module sss_queue
#(
    parameter int          WIDTH    = 32,
    parameter int          DEPTH    = 8,
    parameter bit          SUBST    = 1'b0,
    parameter logic [31:0] OVF_WORD = 32'h0000_0000
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] data_o,
    output logic                  nonempty_o,
    output logic                  full_o
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH > 32)
            $error("sss_queue: bad DEPTH or WIDTH");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             do_pop;
    logic             do_push;
    logic             ovf;
    assign full_o     = (cnt_reg == (AW+1)'(DEPTH));
    assign nonempty_o = (cnt_reg != '0);
    assign data_o     = mem[rd_reg];
    assign do_pop     = pop_i && nonempty_o;
    assign do_push    = push_i && (!full_o || do_pop);
    assign ovf        = push_i && full_o && !do_pop;
    // newest slot sits just behind the write pointer
    always_ff @(posedge clk_i)
    begin
        if (do_push)
            mem[wr_reg] <= data_i;
        else if (SUBST && ovf)
            mem[wr_reg - AW'(1)] <= OVF_WORD[WIDTH-1:0];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (do_push)
                wr_reg <= wr_reg + AW'(1);
            if (do_pop)
                rd_reg <= rd_reg + AW'(1);
            cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : sss_queue
`default_nettype wire

// ===== logic/sss_status.sv
// sss_status: status byte, service request, queues, phase roll-up
// assumes: controller requests are one-cycle strobes on clk_i
//
// What this block does
// - live service summary ORs enabled status bits
// - status query returns summary, changes nothing
// - service request raises line, latches bit 6
// - serial poll returns, clears latched request
// - error queue holds code and text until read
// - overflow replaces newest entry with -350
// - output queue holds replies until read
// - reply waiting sets status bit 4
// - operation roll-up bits 0..2 are phases
// - operation roll-up feeds top bit 13
// - three per-phase operation condition registers
// - bits 4,5 measure running and armed
// - bits 6,7 sequence running and armed
// - bits 8..10 voltage mode, ramp, sync
// - questionable roll-up feeds top bit 13
// - questionable phases at roll-up bits 1..3
// - fault trips at bits 0..4
// - more trips at bits 5..9
// - limiting at bits 10..12, rest zero
// - split-phase mode reports phases 1,2 only
// - groups: condition, filters, event, enable
// - questionable summary drives status bit 3
// - error queue nonempty sets status bit 2
// - enabled operation event sets status bit 7
`timescale 1ns/1ps
`default_nettype none
module sss_status
#(
    parameter int ERR_DEPTH = 8,
    parameter int OUT_DEPTH = 8,
    parameter int OUT_W     = 8
)
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            split_phase_i,
    input  wire logic [3*16-1:0] op_cond_i,
    input  wire logic [3*16-1:0] qu_cond_i,
    input  wire logic [15:0]     top_op_cond_i,
    input  wire logic [15:0]     top_qu_cond_i,
    input  wire logic [15:0]     ptr_i,
    input  wire logic [15:0]     ntr_i,
    input  wire logic [15:0]     grp_enable_i,
    input  wire logic [7:0]      srq_enable_i,
    input  wire logic            esb_i,
    input  wire logic            stb_query_i,
    input  wire logic            serial_poll_i,
    input  wire logic            err_push_i,
    input  wire logic [15:0]     err_code_i,
    input  wire logic [15:0]     err_text_i,
    input  wire logic            err_query_i,
    input  wire logic            reply_push_i,
    input  wire logic [OUT_W-1:0] reply_data_i,
    input  wire logic            reply_read_i,
    input  wire logic            reg_read_i,
    input  wire logic [3:0]      reg_sel_i,
    input  wire logic [1:0]      reg_phase_i,
    output logic                 srq_o,
    output logic [7:0]           stb_reply_o,
    output logic                 stb_valid_o,
    output logic [7:0]           poll_reply_o,
    output logic                 poll_valid_o,
    output logic [31:0]          err_reply_o,
    output logic                 err_valid_o,
    output logic [OUT_W-1:0]     reply_data_o,
    output logic                 reply_valid_o,
    output logic [15:0]          reg_data_o,
    output logic                 reg_valid_o
);
    initial
    begin
        if (OUT_W < 1 || OUT_W > 32)
            $error("sss_status: OUT_W out of range");
    end
    // ************************************************
    // per-phase groups
    // ************************************************
    localparam int NP = sss_pkg::NUM_PHASES;
    logic [NP-1:0] op_ph_sum;
    logic [NP-1:0] qu_ph_sum;
    logic [15:0]   op_ph_ev [NP];
    logic [15:0]   qu_ph_ev [NP];
    logic [NP-1:0] ph_live;
    logic [6:0]    rd_req;
    assign rd_req = {reg_read_i, reg_sel_i, reg_phase_i};
    genvar p;
    generate
        for (p = 0; p < NP; p++)
        begin : g_phase
            sss_grp_if opg ();
            sss_grp_if qug ();
            // phase 3 is silent in split-phase mode
            assign ph_live[p] = !(split_phase_i && p == NP - 1);
            assign opg.cond   = ph_live[p] ?
                op_cond_i[p*16 +: 16] & sss_pkg::OP_USED_MASK
                : sss_pkg::REG_RESET;
            assign qug.cond   = ph_live[p] ?
                qu_cond_i[p*16 +: 16] & sss_pkg::QU_USED_MASK
                : sss_pkg::REG_RESET;
            assign opg.ptr    = ptr_i;
            assign opg.ntr    = ntr_i;
            assign qug.ptr    = ptr_i;
            assign qug.ntr    = ntr_i;
            assign opg.enable = grp_enable_i;
            assign qug.enable = grp_enable_i;
            assign opg.clear  = rd_evt_clr(rd_req, p, 1'b0);
            assign qug.clear  = rd_evt_clr(rd_req, p, 1'b1);
            assign op_ph_sum[p] = opg.summary;
            assign qu_ph_sum[p] = qug.summary;
            assign op_ph_ev[p]  = opg.event_q;
            assign qu_ph_ev[p]  = qug.event_q;
            sss_group u_op (.clk_i(clk_i), .rst_i(rst_i), .g(opg));
            sss_group u_qu (.clk_i(clk_i), .rst_i(rst_i), .g(qug));
        end
    endgenerate
    // event registers clear when software reads them; reg_phase_i 3 reads phase 3 but clears nothing
    // read request passed in so the assigns see every change of it
    function automatic logic rd_evt_clr(input logic [6:0] rq, input int ph,
                                        input logic qu);
        logic [3:0] want;
        want = qu ? sss_pkg::SSS_SEL_QU_STATE : sss_pkg::SSS_SEL_OP_STATE;
        rd_evt_clr = rq[6] && rq[5:2] == want && int'(rq[1:0]) == ph;
    endfunction : rd_evt_clr
    // ************************************************
    // roll-up registers and top groups
    // ************************************************
    logic [15:0] op_rollup;
    logic [15:0] qu_rollup;
    always_comb
    begin
        op_rollup = sss_pkg::REG_RESET;
        qu_rollup = sss_pkg::REG_RESET;
        op_rollup[sss_pkg::OP_PHASE_BASE +: NP] = op_ph_sum;
        qu_rollup[sss_pkg::QU_PHASE_BASE +: NP] = qu_ph_sum;
    end
    sss_grp_if top_op ();
    sss_grp_if top_qu ();
    always_comb
    begin
        top_op.cond = top_op_cond_i;
        top_op.cond[sss_pkg::TOP_PHASE_BIT] = |op_rollup;
        top_qu.cond = top_qu_cond_i;
        top_qu.cond[sss_pkg::TOP_PHASE_BIT] = |qu_rollup;
    end
    assign top_op.ptr    = ptr_i;
    assign top_op.ntr    = ntr_i;
    assign top_qu.ptr    = ptr_i;
    assign top_qu.ntr    = ntr_i;
    assign top_op.enable = grp_enable_i;
    assign top_qu.enable = grp_enable_i;
    assign top_op.clear  = reg_read_i
                           && reg_sel_i == sss_pkg::SSS_SEL_TOP_OP;
    assign top_qu.clear  = reg_read_i
                           && reg_sel_i == sss_pkg::SSS_SEL_TOP_QU;
    sss_group u_top_op (.clk_i(clk_i), .rst_i(rst_i), .g(top_op));
    sss_group u_top_qu (.clk_i(clk_i), .rst_i(rst_i), .g(top_qu));
    // ************************************************
    // error and output queues
    // ************************************************
    logic [31:0]      err_head;
    logic             error_queue_nonempty;
    logic [OUT_W-1:0] out_head;
    logic             reply_waiting;
    sss_queue #(
        .WIDTH    (32),
        .DEPTH    (ERR_DEPTH),
        .SUBST    (1'b1),
        .OVF_WORD ({sss_pkg::ERR_QUEUE_OVERFLOW,
                    sss_pkg::ERR_OVERFLOW_TEXT})
    ) u_err (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .push_i     (err_push_i),
        .data_i     ({err_code_i, err_text_i}),
        .pop_i      (err_query_i),
        .data_o     (err_head),
        .nonempty_o (error_queue_nonempty),
        .full_o     ()
    );
    sss_queue #(
        .WIDTH (OUT_W),
        .DEPTH (OUT_DEPTH)
    ) u_out (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .push_i     (reply_push_i),
        .data_i     (reply_data_i),
        .pop_i      (reply_read_i),
        .data_o     (out_head),
        .nonempty_o (reply_waiting),
        .full_o     ()
    );
    // ************************************************
    // status byte and service request
    // ************************************************
    logic [7:0] stb;
    logic       live_service_summary;
    logic       latched_service_request_reg;
    logic       summary_reg;
    always_comb
    begin
        stb = sss_pkg::BYTE_RESET;
        stb[sss_pkg::STB_ERRQ_BIT]  = error_queue_nonempty;
        stb[sss_pkg::STB_FAULT_BIT] = top_qu.summary;
        stb[sss_pkg::STB_REPLY_BIT] = reply_waiting;
        stb[5]                      = esb_i;
        stb[sss_pkg::STB_NORM_BIT]  = top_op.summary;
    end
    // bit 6 of the enable is ignored, it cannot feed itself
    assign live_service_summary = |(stb & srq_enable_i);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            summary_reg <= 1'b0;
        else
            summary_reg <= live_service_summary;
    end
    // a new rising request wins over a poll clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            latched_service_request_reg <= 1'b0;
        else if (live_service_summary && !summary_reg)
            latched_service_request_reg <= 1'b1;
        else if (serial_poll_i)
            latched_service_request_reg <= 1'b0;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            srq_o <= 1'b0;
        else
            srq_o <= latched_service_request_reg;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stb_reply_o <= sss_pkg::BYTE_RESET;
            stb_valid_o <= 1'b0;
        end
        else
        begin
            stb_valid_o <= stb_query_i;
            if (stb_query_i)
            begin
                stb_reply_o <= stb;
                stb_reply_o[sss_pkg::STB_RQ_BIT] <= live_service_summary;
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            poll_reply_o <= sss_pkg::BYTE_RESET;
            poll_valid_o <= 1'b0;
        end
        else
        begin
            poll_valid_o <= serial_poll_i;
            if (serial_poll_i)
            begin
                poll_reply_o <= stb;
                poll_reply_o[sss_pkg::STB_RQ_BIT]
                    <= latched_service_request_reg;
            end
        end
    end
    // ************************************************
    // queue and register read ports
    // ************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_reply_o   <= 32'h0000_0000;
            err_valid_o   <= 1'b0;
            reply_data_o  <= '0;
            reply_valid_o <= 1'b0;
        end
        else
        begin
            // empty error queue answers code zero
            err_valid_o   <= err_query_i;
            err_reply_o   <= error_queue_nonempty ? err_head
                             : 32'h0000_0000;
            reply_valid_o <= reply_read_i && reply_waiting;
            reply_data_o  <= out_head;
        end
    end
    logic [15:0] rd_mux;
    logic [1:0]  ph;
    always_comb
    begin
        ph = (reg_phase_i > 2'(NP - 1)) ? 2'(NP - 1) : reg_phase_i;
        case (reg_sel_i)
            sss_pkg::SSS_SEL_OP_ROLLUP: rd_mux = op_rollup;
            sss_pkg::SSS_SEL_OP_STATE:  rd_mux = op_ph_ev[ph];
            sss_pkg::SSS_SEL_QU_ROLLUP: rd_mux = qu_rollup;
            sss_pkg::SSS_SEL_QU_STATE:  rd_mux = qu_ph_ev[ph];
            sss_pkg::SSS_SEL_TOP_OP:    rd_mux = top_op.event_q;
            sss_pkg::SSS_SEL_TOP_QU:    rd_mux = top_qu.event_q;
            default:                    rd_mux = sss_pkg::REG_RESET;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_data_o  <= sss_pkg::REG_RESET;
            reg_valid_o <= 1'b0;
        end
        else
        begin
            reg_valid_o <= reg_read_i;
            if (reg_read_i)
                reg_data_o <= rd_mux;
        end
    end
endmodule : sss_status
`default_nettype wire

// ===== verification/sss_status_sva.sv
// sss_status_sva: port-level assertions for sss_status
// assumes: bound onto sss_status, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module sss_status_sva
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  srq_enable_i,
    input wire logic        stb_query_i,
    input wire logic        serial_poll_i,
    input wire logic        err_query_i,
    input wire logic        reply_read_i,
    input wire logic        reg_read_i,
    input wire logic [3:0]  reg_sel_i,
    input wire logic        srq_o,
    input wire logic        stb_valid_o,
    input wire logic        poll_valid_o,
    input wire logic        err_valid_o,
    input wire logic        reply_valid_o,
    input wire logic [15:0] reg_data_o,
    input wire logic        reg_valid_o
);
    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_stb_answer: assert property (
        stb_query_i |=> stb_valid_o) else $error("status query unanswered");
    a_poll_answer: assert property (
        serial_poll_i |=> poll_valid_o) else $error("poll unanswered");
    a_srq_fall_poll: assert property (
        $fell(srq_o) |-> $past(serial_poll_i) || $past(serial_poll_i, 2))
        else $error("request dropped without poll");
    a_query_keeps_srq: assert property (
        stb_query_i && srq_o && !serial_poll_i && !$past(serial_poll_i)
        |=> srq_o) else $error("status query cleared request");
    a_srq_needs_en: assert property (
        $rose(srq_o) |-> (|$past(srq_enable_i)) || (|$past(srq_enable_i, 2))
        || (|$past(srq_enable_i, 3))) else $error("request while disabled");
    a_err_answer: assert property (
        err_query_i |=> err_valid_o) else $error("error query unanswered");
    a_reply_cause: assert property (
        reply_valid_o |-> $past(reply_read_i)) else $error("reply unasked");
    a_reg_answer: assert property (
        reg_read_i |=> reg_valid_o) else $error("register read unanswered");
    a_op_state_bits: assert property (
        reg_read_i && reg_sel_i == 4'h1 |=> (reg_data_o & 16'hF80F) == 16'h0)
        else $error("unused operation bit set");
    a_qu_state_bits: assert property (
        reg_read_i && reg_sel_i == 4'h3 |=> reg_data_o[15:13] == 3'b000)
        else $error("unused questionable bit set");
    a_op_rollup_bits: assert property (
        reg_read_i && reg_sel_i == 4'h0 |=> reg_data_o[15:3] == 13'h0)
        else $error("unused operation roll-up bit set");
    a_qu_rollup_bits: assert property (
        reg_read_i && reg_sel_i == 4'h2 |=> (reg_data_o & 16'hFFF1) == 16'h0)
        else $error("unused questionable roll-up bit set");
    c_poll_clear: cover property ($fell(srq_o));
    c_err_read: cover property (err_valid_o);
    c_phase_read: cover property (reg_valid_o && reg_data_o == 16'h07F0);
endmodule : sss_status_sva
`default_nettype wire

// ===== verification/sss_ctl_model.sv
// sss_ctl_model: remote controller issuing queries and polls
// assumes: requests launched at falling edge, answer one cycle on
`timescale 1ns/1ps
`default_nettype none
module sss_ctl_model
(
    input  wire logic       clk_i,
    input  wire logic [4:0] valid_i,
    output logic      [4:0] req_o,
    output logic      [3:0] sel_o,
    output logic      [1:0] phase_o
);
    // ************************************************
    // request task: 0 status, 1 poll, 2 error, 3 reply, 4 reg
    // ************************************************
    initial {req_o, sel_o, phase_o} = 11'h000;
    task automatic ask(input int k, input logic [3:0] s,
                       input logic [1:0] p, output logic v);
        @(negedge clk_i);
        req_o[k] = 1'b1;
        sel_o = s;
        phase_o = p;
        @(negedge clk_i);
        req_o = 5'h00;
        sel_o = ~s;
        phase_o = ~p;
        v = valid_i[k];
    endtask : ask
endmodule : sss_ctl_model
`default_nettype wire

// ===== verification/tb_top.sv
// tb_top: scenario bench for sss_status
// assumes: controller model issues requests, bench drives the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_top;
    localparam int ED = 4;
    logic        clk_i = 1'b0, rst_i = 1'b1, split_phase_i = 1'b0, v;
    logic        err_push_i = 1'b0, reply_push_i = 1'b0, srq_o;
    logic [47:0] op_cond_i = 48'h0, qu_cond_i = 48'h0;
    logic [15:0] ptr_i = 16'hFFFF, ntr_i = 16'h0, grp_enable_i = 16'hFFFF;
    logic [15:0] err_code_i = 16'h0, err_text_i = 16'h0, reg_data_o;
    logic [7:0]  srq_enable_i = 8'h0, reply_data_i = 8'h0;
    logic [7:0]  stb_reply_o, poll_reply_o, reply_data_o;
    logic [31:0] err_reply_o;
    logic [4:0]  req, vld;
    logic [3:0]  sel;
    logic [1:0]  ph;
    logic        stb_valid_o, poll_valid_o, err_valid_o;
    logic        reply_valid_o, reg_valid_o;
    int          n_fail = 0, cmp_count = 0;
    assign vld = {reg_valid_o, reply_valid_o, err_valid_o, poll_valid_o,
                  stb_valid_o};
    sss_status #(.ERR_DEPTH(ED), .OUT_DEPTH(2), .OUT_W(8)) u_sss_status (
        .clk_i, .rst_i, .split_phase_i, .op_cond_i, .qu_cond_i,
        .top_op_cond_i(16'h0), .top_qu_cond_i(16'h0), .ptr_i, .ntr_i,
        .grp_enable_i, .srq_enable_i, .esb_i(1'b0), .stb_query_i(req[0]),
        .serial_poll_i(req[1]), .err_push_i, .err_code_i, .err_text_i,
        .err_query_i(req[2]), .reply_push_i, .reply_data_i,
        .reply_read_i(req[3]), .reg_read_i(req[4]), .reg_sel_i(sel),
        .reg_phase_i(ph), .srq_o, .stb_reply_o, .stb_valid_o, .poll_reply_o,
        .poll_valid_o, .err_reply_o, .err_valid_o, .reply_data_o,
        .reply_valid_o, .reg_data_o, .reg_valid_o);
    sss_ctl_model u_sss_ctl_model (.clk_i, .valid_i(vld), .req_o(req),
                                   .sel_o(sel), .phase_o(ph));
    // ************************************************
    // clock, helpers
    // ************************************************
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic ask(input int k, input logic [3:0] s = 4'h0,
                       input logic [1:0] p = 2'h0);
        u_sss_ctl_model.ask(k, s, p, v);
    endtask : ask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
    endtask : do_reset
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_service();
        srq_enable_i = 8'h2C;
        reply_push_i = 1'b1;
        reply_data_i = 8'hA5;
        @(negedge clk_i);
        reply_data_i = 8'h3C;
        @(negedge clk_i);
        reply_data_i = 8'hFF; // queue full, dropped
        @(negedge clk_i);
        reply_push_i = 1'b0;
        ask(0);
        `CHK("stb masked", 8'h10, stb_reply_o)
        srq_enable_i = 8'h10;
        repeat (3) @(negedge clk_i);
        `CHK("srq raised", 1'b1, srq_o)
        ask(0);
        ask(0);
        `CHK("stb again", 8'h50, stb_reply_o)
        `CHK("srq kept", 1'b1, srq_o)
        ask(1);
        `CHK("poll first", 8'h50, poll_reply_o)
        ask(1);
        `CHK("poll second", 8'h10, poll_reply_o)
        `CHK("srq cleared", 1'b0, srq_o)
        ask(3);
        `CHK("reply 1", 8'hA5, reply_data_o)
        ask(3);
        `CHK("reply 2", 8'h3C, reply_data_o)
        ask(3);
        `CHK("reply empty", 1'b0, v)
        ask(0);
        `CHK("stb drained", 8'h00, stb_reply_o)
        srq_enable_i = 8'h00;
    endtask : t_service
    task automatic t_error();
        for (int i = 0; i <= ED; i++)
        begin
            @(negedge clk_i);
            err_push_i = 1'b1;
            err_code_i = 16'h0100 + 16'(i);
            err_text_i = 16'h0A00 + 16'(i);
        end
        @(negedge clk_i);
        err_push_i = 1'b0;
        ask(0);
        `CHK("stb errq", 8'h04, stb_reply_o)
        for (int i = 0; i < ED - 1; i++)
        begin
            ask(2);
            `CHK("err entry", {16'h0100 + 16'(i), 16'h0A00 + 16'(i)},
                 err_reply_o)
        end
        ask(2);
        `CHK("err ovf", {16'hFEA2, sss_pkg::ERR_OVERFLOW_TEXT}, err_reply_o)
        ask(2);
        `CHK("err empty", 32'h0, err_reply_o)
        ask(0);
        `CHK("stb noerr", 8'h00, stb_reply_o)
    endtask : t_error
    task automatic t_groups();
        op_cond_i = {3{16'hFFFF}};
        qu_cond_i = {3{16'hFFFF}};
        repeat (8) @(negedge clk_i);
        ask(0);
        `CHK("stb groups", 8'h88, stb_reply_o)
        ask(4, 4'h0);
        `CHK("op rollup", 16'h0007, reg_data_o)
        ask(4, 4'h2);
        `CHK("qu rollup", 16'h000E, reg_data_o)
        ask(4, 4'h4);
        `CHK("top op", 16'h2000, reg_data_o)
        ask(4, 4'h5);
        `CHK("top qu", 16'h2000, reg_data_o)
        for (int p = 0; p < 3; p++)
        begin
            ask(4, 4'h1, 2'(p));
            `CHK("op phase", 16'h07F0, reg_data_o)
            ask(4, 4'h3, 2'(p));
            `CHK("qu phase", 16'h1FFF, reg_data_o)
        end
        ask(4, 4'h1);
        `CHK("op cleared", 16'h0000, reg_data_o)
        ptr_i = 16'h0000;
        ntr_i = 16'hFFFF;
        op_cond_i[15:0] = 16'h0000;
        repeat (4) @(negedge clk_i);
        ask(4, 4'h1);
        `CHK("op falling", 16'h07F0, reg_data_o)
    endtask : t_groups
    task automatic t_split();
        ptr_i = 16'hFFFF;
        split_phase_i = 1'b1;
        do_reset();
        op_cond_i = {3{16'hFFFF}};
        qu_cond_i = {3{16'hFFFF}};
        repeat (8) @(negedge clk_i);
        ask(4, 4'h0);
        `CHK("split op", 16'h0003, reg_data_o)
        ask(4, 4'h2);
        `CHK("split qu", 16'h0006, reg_data_o)
        ask(4, 4'h1, 2'h2);
        `CHK("split ph3", 16'h0000, reg_data_o)
    endtask : t_split
    // ************************************************
    // main sequence and hang guard
    // ************************************************
    initial
    begin
        do_reset();
        t_service();
        t_error();
        t_groups();
        t_split();
        report_and_stop();
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        report_and_stop();
    end
endmodule : tb_top
bind sss_status sss_status_sva u_sss_status_sva (
    .clk_i, .rst_i, .srq_enable_i, .stb_query_i, .serial_poll_i,
    .err_query_i, .reply_read_i, .reg_read_i, .reg_sel_i, .srq_o,
    .stb_valid_o, .poll_valid_o, .err_valid_o, .reply_valid_o,
    .reg_data_o, .reg_valid_o);
`default_nettype wire
